// >>> hdl/fifo_pkg.sv
// Constants and helper functions shared by the flagged FIFO design
package fifo_pkg;
    // ------------------------------------------------------------
    // Geometry of one configurable_memory_block
    // ------------------------------------------------------------
    localparam int CAP_BITS    = 16384;
    localparam int DATA_W      = 8;
    localparam int DEPTH       = CAP_BITS / DATA_W;
    localparam int ADDR_W      = $clog2(DEPTH);
    localparam int PTR_W       = ADDR_W + 1;

    // ------------------------------------------------------------
    // Default flag offsets and reset values
    // ------------------------------------------------------------
    localparam int AFULL_OFS_DEF  = 16;
    localparam int AEMPTY_OFS_DEF = 16;
    localparam int SYNC_STAGES    = 2;

    localparam logic [PTR_W-1:0]  PTR_RST   = '0;
    localparam logic [DATA_W-1:0] DATA_RST  = '0;
    localparam logic              FULL_RST  = 1'b0;
    localparam logic              AFULL_RST = 1'b0;
    localparam logic              EMPTY_N_RST  = 1'b0;
    localparam logic              AEMPTY_N_RST = 1'b0;
    localparam logic [PTR_W-1:0]  PTR_ONE   = {{(PTR_W-1){1'b0}}, 1'b1};
    localparam logic [PTR_W-1:0]  DEPTH_PTR = PTR_W'(DEPTH);

    typedef logic [PTR_W-1:0] ptr_t;

    function automatic ptr_t bin2gray(input ptr_t b);
        return b ^ (b >> 1);
    endfunction

    function automatic ptr_t gray2bin(input ptr_t g);
        ptr_t b;
        // Top bit passes straight through; each lower bit folds in the one above
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction
endpackage

// >>> hdl/ptr_sync.sv
// Two-stage synchroniser for a Gray-coded pointer
`timescale 1ns/1ps
module ptr_sync (
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    input  wire logic [fifo_pkg::PTR_W-1:0] gray_in,
    output logic      [fifo_pkg::PTR_W-1:0] gray_out
);
    import fifo_pkg::*;

    logic [PTR_W-1:0] meta_ff;
    logic [PTR_W-1:0] sync_ff;
    logic [PTR_W-1:0] nxt_meta;
    logic [PTR_W-1:0] nxt_sync;

    // First stage feeds only the second stage
    always_comb begin
        nxt_meta = gray_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= PTR_RST;
            sync_ff <= PTR_RST;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign gray_out = sync_ff;
endmodule

// >>> hdl/flagged_fifo.sv
// Flagged FIFO with write-side and read-side clock enables and retransmit
`timescale 1ns/1ps

// How it works
// - Write and read ports run on their own enables; shared timing also works.
// - Fill state shown by four flags: full, almost full, empty, almost empty.
// - Empty and almost empty are active low; full and almost full active high.
// - Both thresholds are build-time parameters from one to the full depth.
// - Almost full near the top by its offset; almost empty near bottom.
// - A rewind control returns the read pointer to start for retransmission.
// - One block holds 16384 bits; depth equals capacity divided by width.
// - Side-by-side blocks widen with no extra logic; deeper needs outer counters.
// - Data, enables, flags and read data all pass through registers.
// - Write capture, full and almost full use the write enable timing.
// - Read data, empty and almost empty use the read enable timing.
// - One reset clears every register on both sides.
// - Full flags derive from write side, change only on write steps.
// - Empty flags derive from read side, change only on read steps.
// - Writes when full and reads when empty change nothing.
module flagged_fifo #(
    parameter int AFULL_OFS  = fifo_pkg::AFULL_OFS_DEF,
    parameter int AEMPTY_OFS = fifo_pkg::AEMPTY_OFS_DEF
) (
    input  wire logic                        clk_sys,
    input  wire logic                        arst_n,
    input  wire logic                        wr_clk_en,
    input  wire logic                        wr_en,
    input  wire logic [fifo_pkg::DATA_W-1:0] wr_data,
    input  wire logic                        rd_clk_en,
    input  wire logic                        rd_en,
    input  wire logic                        rd_rewind,
    output logic      [fifo_pkg::DATA_W-1:0] rd_data,
    output logic                             full,
    output logic                             almost_full,
    output logic                             empty_n,
    output logic                             almost_empty_n
);
    import fifo_pkg::*;

    localparam ptr_t AFULL_LVL  = PTR_W'(DEPTH - AFULL_OFS);
    localparam ptr_t AEMPTY_LVL = PTR_W'(AEMPTY_OFS);

    // ------------------------------------------------------------
    // Storage: one block deep, DATA_W wide
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_ff [DEPTH];

    // ------------------------------------------------------------
    // Write side state
    // ------------------------------------------------------------
    ptr_t  wr_ptr_ff,  nxt_wr_ptr;
    ptr_t  wr_gray_ff, nxt_wr_gray;
    logic  full_ff,    nxt_full;
    logic  afull_ff,   nxt_afull;
    logic  wr_do;
    ptr_t  rd_gray_sync;
    ptr_t  rd_bin_sync;
    ptr_t  wr_level;

    // Inputs sampled on the write step, so a pulse between steps is ignored
    assign wr_do = wr_clk_en && wr_en && !full_ff;

    always_comb begin
        rd_bin_sync = gray2bin(rd_gray_sync);
        nxt_wr_ptr  = wr_ptr_ff;
        nxt_wr_gray = wr_gray_ff;
        nxt_full    = full_ff;
        nxt_afull   = afull_ff;
        wr_level    = wr_ptr_ff - rd_bin_sync;
        if (wr_clk_en) begin
            if (wr_do) begin
                nxt_wr_ptr = wr_ptr_ff + PTR_ONE;
            end
            nxt_wr_gray = bin2gray(nxt_wr_ptr);
            wr_level    = nxt_wr_ptr - rd_bin_sync;
            // Level can exceed depth after a rewind; treat that as full
            nxt_full    = (wr_level >= DEPTH_PTR);
            nxt_afull   = (wr_level >= AFULL_LVL);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_ff  <= PTR_RST;
            wr_gray_ff <= PTR_RST;
            full_ff    <= FULL_RST;
            afull_ff   <= AFULL_RST;
        end else begin
            wr_ptr_ff  <= nxt_wr_ptr;
            wr_gray_ff <= nxt_wr_gray;
            full_ff    <= nxt_full;
            afull_ff   <= nxt_afull;
        end
    end

    // ------------------------------------------------------------
    // Memory entries, each written only on an accepted write
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            logic [DATA_W-1:0] nxt_entry;
            always_comb begin
                nxt_entry = mem_ff[gi];
                if (wr_do && (wr_ptr_ff[ADDR_W-1:0] == ADDR_W'(gi))) begin
                    nxt_entry = wr_data;
                end
            end
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    mem_ff[gi] <= DATA_RST;
                end else begin
                    mem_ff[gi] <= nxt_entry;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read side state
    // ------------------------------------------------------------
    ptr_t              rd_ptr_ff,  nxt_rd_ptr;
    ptr_t              rd_gray_ff, nxt_rd_gray;
    logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
    logic              empty_n_ff, nxt_empty_n;
    logic              aempty_n_ff, nxt_aempty_n;
    logic              rd_do;
    ptr_t              wr_gray_sync;
    ptr_t              wr_bin_sync;
    ptr_t              rd_level;

    assign rd_do = rd_clk_en && rd_en && empty_n_ff;

    always_comb begin
        wr_bin_sync  = gray2bin(wr_gray_sync);
        nxt_rd_ptr   = rd_ptr_ff;
        nxt_rd_gray  = rd_gray_ff;
        nxt_rd_data  = rd_data_ff;
        nxt_empty_n  = empty_n_ff;
        nxt_aempty_n = aempty_n_ff;
        rd_level     = wr_bin_sync - rd_ptr_ff;
        if (rd_clk_en) begin
            if (rd_rewind) begin
                // Rewind wins over a read in the same step
                nxt_rd_ptr = PTR_RST;
            end else if (rd_do) begin
                nxt_rd_data = mem_ff[rd_ptr_ff[ADDR_W-1:0]];
                nxt_rd_ptr  = rd_ptr_ff + PTR_ONE;
            end
            nxt_rd_gray  = bin2gray(nxt_rd_ptr);
            rd_level     = wr_bin_sync - nxt_rd_ptr;
            nxt_empty_n  = (rd_level != PTR_RST);
            nxt_aempty_n = (rd_level > AEMPTY_LVL);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_ptr_ff   <= PTR_RST;
            rd_gray_ff  <= PTR_RST;
            rd_data_ff  <= DATA_RST;
            empty_n_ff  <= EMPTY_N_RST;
            aempty_n_ff <= AEMPTY_N_RST;
        end else begin
            rd_ptr_ff   <= nxt_rd_ptr;
            rd_gray_ff  <= nxt_rd_gray;
            rd_data_ff  <= nxt_rd_data;
            empty_n_ff  <= nxt_empty_n;
            aempty_n_ff <= nxt_aempty_n;
        end
    end

    // ------------------------------------------------------------
    // Pointer crossings; kept even with one clock so timing of
    // the two ports stays independent
    // ------------------------------------------------------------
    ptr_sync u_rd_to_wr (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .gray_in  (rd_gray_ff),
        .gray_out (rd_gray_sync)
    );

    ptr_sync u_wr_to_rd (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .gray_in  (wr_gray_ff),
        .gray_out (wr_gray_sync)
    );

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign rd_data        = rd_data_ff;
    assign full           = full_ff;
    assign almost_full    = afull_ff;
    assign empty_n        = empty_n_ff;
    assign almost_empty_n = aempty_n_ff;
endmodule

// >>> verification/flagged_fifo_properties.sv
// Port-level concurrent checks for the flagged FIFO
`timescale 1ns/1ps
module flagged_fifo_checker (
    input wire logic                        clk_sys,
    input wire logic                        arst_n,
    input wire logic                        wr_clk_en,
    input wire logic                        wr_en,
    input wire logic [fifo_pkg::DATA_W-1:0] wr_data,
    input wire logic                        rd_clk_en,
    input wire logic                        rd_en,
    input wire logic                        rd_rewind,
    input wire logic [fifo_pkg::DATA_W-1:0] rd_data,
    input wire logic                        full,
    input wire logic                        almost_full,
    input wire logic                        empty_n,
    input wire logic                        almost_empty_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_wr_flags_hold: assert property (!wr_clk_en |=> $stable({full, almost_full}))
        else $error("write flags moved off a write step");
    a_rd_flags_hold: assert property (!rd_clk_en |=> $stable({empty_n, almost_empty_n}))
        else $error("read flags moved off a read step");
    a_full_by_write: assert property ($rose(full) |-> $past(wr_clk_en) && $past(wr_en))
        else $error("full rose without a write");
    a_empty_by_read: assert property ($fell(empty_n) |-> $past(rd_clk_en) && $past(rd_en))
        else $error("empty rose without a read");
    a_ae_by_read: assert property ($fell(almost_empty_n) |-> $past(rd_en))
        else $error("almost empty rose without a read");
    a_full_has_af: assert property (full |-> almost_full)
        else $error("full without almost full");
    a_empty_has_ae: assert property (!empty_n |-> !almost_empty_n)
        else $error("empty without almost empty");
    a_rd_data_hold: assert property (!(rd_clk_en && rd_en && empty_n) |=> $stable(rd_data))
        else $error("read data moved without a read");
    a_rewind_no_read: assert property (rd_clk_en && rd_rewind |=> $stable(rd_data))
        else $error("read data moved on a rewind step");
    c_full: cover property (full);
    c_rewind: cover property (rd_clk_en && rd_rewind);
    c_not_empty: cover property ($rose(empty_n));
endmodule

bind flagged_fifo flagged_fifo_checker chk (.clk_sys, .arst_n, .wr_clk_en, .wr_en, .wr_data,
    .rd_clk_en, .rd_en, .rd_rewind, .rd_data, .full, .almost_full, .empty_n, .almost_empty_n);

// >>> verification/port_steps.sv
// Producer and consumer step model for the two FIFO ports
`timescale 1ns/1ps
module port_steps (
    input  wire logic clk_sys,
    input  wire logic slow,
    output logic      wr_clk_en = 1'b1,
    output logic      rd_clk_en = 1'b1
);
    int n = 0;
    // Unequal rates stand in for unrelated port clocks
    always @(posedge clk_sys) begin
        n <= n + 1;
        wr_clk_en <= #1 !slow || n % 2 == 0;
        rd_clk_en <= #1 !slow || n % 3 == 1;
    end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the flagged FIFO against an array reference model
`timescale 1ns/1ps
module testbench;
    import fifo_pkg::*;
    localparam int AF = 5;
    localparam int AE = 3;
    logic              clk_sys = 1'b0, arst_n = 1'b0, slow = 1'b0, pend = 1'b0;
    logic              wr_en = 1'b0, rd_en = 1'b0, rd_rewind = 1'b0, wr_clk_en, rd_clk_en;
    logic              full, almost_full, empty_n, almost_empty_n;
    logic [DATA_W-1:0] wr_data = '0, rd_data, exp_rd, mem [DEPTH];
    logic [31:0]       rnd = 32'h4716;
    int                wp = 0, rp = 0, fails = 0, n_compared = 0, lvl;
    assign lvl = wp - rp;
    initial forever #12.5 clk_sys = ~clk_sys;
    port_steps steps (.clk_sys, .slow, .wr_clk_en, .rd_clk_en);
    flagged_fifo #(.AFULL_OFS(AF), .AEMPTY_OFS(AE)) dut (.clk_sys, .arst_n, .wr_clk_en, .wr_en,
        .wr_data, .rd_clk_en, .rd_en, .rd_rewind, .rd_data, .full, .almost_full, .empty_n,
        .almost_empty_n);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t data %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flags(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t flags %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    // Idle both ports long enough for the pointer crossing to land
    task automatic settle();
        {wr_en, rd_en, rd_rewind, slow} = 4'h0;
        repeat (8) tick();
        cmp_flags({full, almost_full, empty_n, almost_empty_n},
            {lvl >= DEPTH, lvl >= DEPTH - AF, lvl != 0, lvl > AE});
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Reference model, judged on pre-edge flags as the design is
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {wp, rp, pend} = '0;
        end else begin
            if (pend) cmp_data(rd_data, exp_rd);
            pend = 1'b0;
            if (wr_clk_en && wr_en && full === 1'b0) begin
                mem[wp % DEPTH] = wr_data;
                wp++;
            end
            if (rd_clk_en && rd_rewind) rp = 0;
            else if (rd_clk_en && rd_en && empty_n === 1'b1) begin
                exp_rd = mem[rp % DEPTH];
                rp++;
                pend = 1'b1;
            end
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        cmp_data(rd_data, '0);
        settle();
        rd_en = 1'b1;
        repeat (3) tick();
        cmp_data(rd_data, '0);
        for (int i = 0; i < AE + 2; i++) begin
            rnd = lfsr(rnd);
            {wr_en, wr_data} = {1'b1, rnd[7:0]};
            tick();
            settle();
        end
        rd_en = 1'b1;
        repeat (2) tick();
        // Rewind together with a read request: the rewind must win
        {rd_en, rd_rewind} = 2'b11;
        tick();
        settle();
        rd_en = 1'b1;
        repeat (AE + 3) tick();
        wr_en = 1'b1;
        repeat (3) tick();
        arst_n = 1'b0;
        tick();
        cmp_flags({full, almost_full, empty_n, almost_empty_n}, 4'h0);
        arst_n = 1'b1;
        settle();
        for (int i = 0; i < 3000 && full !== 1'b1; i++) begin
            rnd = lfsr(rnd);
            {wr_en, wr_data} = {1'b1, rnd[7:0]};
            tick();
            if (lvl == DEPTH - AF - 1 || lvl == DEPTH - AF) settle();
        end
        if (full !== 1'b1) fails++;
        wr_en = 1'b1;
        repeat (3) tick();
        settle();
        slow = 1'b1;
        // Slow steps with random stalls on both sides
        for (int i = 0; i < 30000 && (lvl != 0 || empty_n !== 1'b0); i++) begin
            rnd = lfsr(rnd);
            {rd_en, wr_en, wr_data} = {rnd[0] | rnd[4], &rnd[3:1], rnd[15:8]};
            tick();
        end
        if (lvl != 0) fails++;
        settle();
        give_verdict();
    end
endmodule
